/* core/lccr_regs.sv */
// Purpose: Storage for the five configuration bytes with a registered read port.
// Assumes: Write strobe, index and data come from logic on the same clock.
// Notes: All eight bits are stored, reserved ones included, so a read returns what was written.
`timescale 1ns/1ps
`default_nettype none
module lccr_regs
  import lccr_pkg::*;
#(
  parameter int DEPTH = NUM_REGS
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic wr_en_in,
  input wire logic [2:0] wr_idx_in,
  input wire logic [7:0] wr_data_in,
  input wire logic [2:0] rd_idx_in,
  output logic [7:0] rd_data_out,
  output logic [DEPTH-1:0][7:0] regs_out
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  if (DEPTH != NUM_REGS) begin : g_depth_check
    $error("lccr_regs: DEPTH must equal the number of mapped registers");
  end

  logic [DEPTH-1:0][7:0] mem_r;
  logic [DEPTH-1:0][7:0] mem_nxt;
  logic [7:0] rd_r;
  logic [7:0] rd_nxt;

  always_comb begin
    mem_nxt = mem_r;
    rd_nxt = 8'h00;
    if (wr_en_in && (32'(wr_idx_in) < DEPTH)) begin
      mem_nxt[wr_idx_in] = wr_data_in;
    end
    if (32'(rd_idx_in) < DEPTH) begin
      rd_nxt = mem_r[rd_idx_in];
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mem_r <= RST_ALL;
      rd_r <= 8'h00;
    end else begin
      mem_r <= mem_nxt;
      rd_r <= rd_nxt;
    end
  end

  assign rd_data_out = rd_r;
  assign regs_out = mem_r;

endmodule
`default_nettype wire

/* core/lccr_top.sv */
// Purpose: Two-wire management slave holding the lane conditioning settings and their decoded form.
// Assumes: Bus pins and detector levels are asynchronous and are sampled by sys_clk_in.
// Notes: The pointer does not advance; each data byte of a transfer goes to the same register.
`timescale 1ns/1ps
`default_nettype none
module lccr_top
  import lccr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h58
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic smb_clk_in,
  input wire logic smb_data_in,
  output logic smb_data_out,
  output logic smb_data_oe_n_out,
  input wire logic lane0_output_a_idle_detect_in,
  input wire logic lane0_output_a_rate_detect_in,
  output lccr_cond_t cond_out
);

  if (DEV_ADDR < 7'h08 || DEV_ADDR > 7'h77) begin : g_addr_check
    $error("lccr_top: DEV_ADDR falls in a reserved address range");
  end

  // ****************************************************************
  // Pin synchronisers and edge finding
  // ****************************************************************
  // The third stage feeds only the edge finders, so stage one stays private.
  logic [3:0] sy1_r, sy1_nxt, sy2_r, sy2_nxt;
  logic scl_d_r, scl_d_nxt, sda_d_r, sda_d_nxt;

  always_comb begin
    sy1_nxt = {lane0_output_a_rate_detect_in, lane0_output_a_idle_detect_in, smb_data_in, smb_clk_in};
    sy2_nxt = sy1_r;
    scl_d_nxt = sy2_r[0];
    sda_d_nxt = sy2_r[1];
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sy1_r <= 4'hF;
      sy2_r <= 4'hF;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      sy1_r <= sy1_nxt;
      sy2_r <= sy2_nxt;
      scl_d_r <= scl_d_nxt;
      sda_d_r <= sda_d_nxt;
    end
  end

  logic scl, sda, scl_rise, scl_fall, bus_start, bus_stop;
  assign scl = sy2_r[0];
  assign sda = sy2_r[1];
  assign scl_rise = scl & ~scl_d_r;
  assign scl_fall = ~scl & scl_d_r;
  assign bus_start = scl & scl_d_r & sda_d_r & ~sda;
  assign bus_stop = scl & scl_d_r & ~sda_d_r & sda;

  // ****************************************************************
  // Bus protocol engine
  // ****************************************************************
  lccr_state_t state_r, state_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic done_r, done_nxt, rw_r, rw_nxt, mack_r, mack_nxt;
  logic oe_n_r, oe_n_nxt, wr_en_r, wr_en_nxt;
  logic [7:0] shift_r, shift_nxt, ptr_r, ptr_nxt, wr_data_r, wr_data_nxt;
  logic [2:0] wr_idx_r, wr_idx_nxt;
  logic [3:0] wr_map, rd_map;
  logic [7:0] rd_data, rd_byte;
  logic [NUM_REGS-1:0][7:0] regs_w;

  assign wr_map = lccr_map(ptr_r);
  assign rd_map = lccr_map(ptr_r);
  // Unmapped pointers read as zero and swallow writes, yet are still acknowledged.
  assign rd_byte = rd_map[3] ? rd_data : 8'h00;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    done_nxt = done_r;
    rw_nxt = rw_r;
    mack_nxt = mack_r;
    oe_n_nxt = oe_n_r;
    shift_nxt = shift_r;
    ptr_nxt = ptr_r;
    wr_en_nxt = 1'b0;
    wr_idx_nxt = wr_idx_r;
    wr_data_nxt = wr_data_r;
    if (bus_stop) begin
      state_nxt = ST_IDLE;
      oe_n_nxt = 1'b1;
    end else if (bus_start) begin
      state_nxt = ST_ADDR;
      cnt_nxt = 3'h0;
      done_nxt = 1'b0;
      oe_n_nxt = 1'b1;
    end else begin
      unique case (state_r)
        ST_IDLE, ST_SKIP: begin
          oe_n_nxt = 1'b1;
        end
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (scl_rise) begin
            shift_nxt = {shift_r[6:0], sda};
            cnt_nxt = cnt_r + 3'h1;
            done_nxt = (cnt_r == 3'h7);
          end else if (scl_fall && done_r) begin
            done_nxt = 1'b0;
            oe_n_nxt = 1'b0;
            if (state_r == ST_ADDR) begin
              if (shift_r[7:1] == DEV_ADDR) begin
                rw_nxt = shift_r[0];
                state_nxt = ST_ADDR_ACK;
              end else begin
                oe_n_nxt = 1'b1;
                state_nxt = ST_SKIP;
              end
            end else if (state_r == ST_PTR) begin
              ptr_nxt = shift_r;
              state_nxt = ST_PTR_ACK;
            end else begin
              wr_en_nxt = wr_map[3];
              wr_idx_nxt = wr_map[2:0];
              wr_data_nxt = shift_r;
              state_nxt = ST_WDATA_ACK;
            end
          end
        end
        ST_ADDR_ACK, ST_PTR_ACK, ST_WDATA_ACK: begin
          if (scl_fall) begin
            cnt_nxt = 3'h0;
            if (state_r == ST_ADDR_ACK && rw_r) begin
              shift_nxt = rd_byte;
              oe_n_nxt = rd_byte[7];
              state_nxt = ST_RDATA;
            end else begin
              oe_n_nxt = 1'b1;
              state_nxt = (state_r == ST_ADDR_ACK) ? ST_PTR : ST_WDATA;
            end
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            cnt_nxt = cnt_r + 3'h1;
            done_nxt = (cnt_r == 3'h7);
          end else if (scl_fall) begin
            if (done_r) begin
              done_nxt = 1'b0;
              oe_n_nxt = 1'b1;
              state_nxt = ST_RDATA_ACK;
            end else begin
              oe_n_nxt = shift_r[3'h7 - cnt_r];
            end
          end
        end
        ST_RDATA_ACK: begin
          if (scl_rise) begin
            mack_nxt = ~sda;
          end else if (scl_fall) begin
            cnt_nxt = 3'h0;
            if (mack_r) begin
              shift_nxt = rd_byte;
              oe_n_nxt = rd_byte[7];
              state_nxt = ST_RDATA;
            end else begin
              oe_n_nxt = 1'b1;
              state_nxt = ST_SKIP;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= ST_IDLE;
      cnt_r <= 3'h0;
      done_r <= 1'b0;
      rw_r <= 1'b0;
      mack_r <= 1'b0;
      oe_n_r <= 1'b1;
      shift_r <= 8'h00;
      ptr_r <= 8'h00;
      wr_en_r <= 1'b0;
      wr_idx_r <= 3'h0;
      wr_data_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
      rw_r <= rw_nxt;
      mack_r <= mack_nxt;
      oe_n_r <= oe_n_nxt;
      shift_r <= shift_nxt;
      ptr_r <= ptr_nxt;
      wr_en_r <= wr_en_nxt;
      wr_idx_r <= wr_idx_nxt;
      wr_data_r <= wr_data_nxt;
    end
  end

  lccr_regs #(
    .DEPTH(NUM_REGS)
  ) u_regs (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .wr_en_in(wr_en_r),
    .wr_idx_in(wr_idx_r),
    .wr_data_in(wr_data_r),
    .rd_idx_in(rd_map[2:0]),
    .rd_data_out(rd_data),
    .regs_out(regs_w)
  );

  // ****************************************************************
  // Setting decode
  // ****************************************************************
  function automatic logic [7:0] thr_mv(input logic [1:0] code, input logic deassert);
    unique case (code)
      2'b00: thr_mv = deassert ? 8'h6E : 8'h46;
      2'b01: thr_mv = deassert ? 8'h96 : 8'h6E;
      2'b10: thr_mv = deassert ? 8'hAA : 8'h82;
      2'b11: thr_mv = deassert ? 8'hBE : 8'h96;
    endcase
  endfunction

  lccr_cond_t cond_r, cond_nxt;
  logic sdata_r;
  logic [7:0] eq_b, sw_b, de_b, th_b, ir_b;

  always_comb begin
    eq_b = regs_w[IDX_EQ];
    sw_b = regs_w[IDX_SWING];
    de_b = regs_w[IDX_DEEMPH];
    th_b = regs_w[IDX_IDLE_THR];
    ir_b = regs_w[IDX_IDLE_RATE];
    cond_nxt = '0;
    // Bits 7:6 of the equalizer byte take no part in the decode.
    cond_nxt.eq_enable = eq_b[EQ_EN_BIT];
    cond_nxt.gain_stage = eq_b[STAGE_HI:STAGE_LO];
    cond_nxt.boost_level = eq_b[BOOST_HI:0];
    // Stage code zero is unused, so stages 1 to 3 give levels 0 to 23.
    cond_nxt.eq_level_valid = eq_b[EQ_EN_BIT] && (eq_b[STAGE_HI:STAGE_LO] != 2'b00);
    cond_nxt.eq_level = cond_nxt.eq_level_valid ? {eq_b[STAGE_HI:STAGE_LO] - 2'b01, eq_b[BOOST_HI:0]} : 5'h00;
    cond_nxt.eq_code_listed = 1'b1;
    unique case (eq_b[5:0])
      6'h20: cond_nxt.eq_boost_tenth_db = 9'h000;
      6'h2A: cond_nxt.eq_boost_tenth_db = 9'h032;
      6'h30: cond_nxt.eq_boost_tenth_db = 9'h05A;
      6'h32: cond_nxt.eq_boost_tenth_db = 9'h075;
      6'h39: cond_nxt.eq_boost_tenth_db = 9'h092;
      6'h35: cond_nxt.eq_boost_tenth_db = 9'h0B8;
      6'h37: cond_nxt.eq_boost_tenth_db = 9'h0C8;
      6'h3B: cond_nxt.eq_boost_tenth_db = 9'h0D4;
      6'h3D: cond_nxt.eq_boost_tenth_db = 9'h11C;
      default: cond_nxt.eq_code_listed = 1'b0;
    endcase
    // The reserved swing code 3F and unlisted codes leave the swing marked invalid.
    cond_nxt.output_swing_valid = 1'b1;
    unique case (sw_b[SWING_HI:0])
      7'h03: cond_nxt.output_swing_mv = 11'h258;
      7'h07: cond_nxt.output_swing_mv = 11'h320;
      7'h0F: cond_nxt.output_swing_mv = 11'h3E8;
      7'h1F: cond_nxt.output_swing_mv = 11'h4B0;
      default: cond_nxt.output_swing_valid = 1'b0;
    endcase
    cond_nxt.deemphasis_kind = de_b[DEEMPH_KIND_BIT];
    cond_nxt.deemphasis_level = de_b[DEEMPH_LVL_HI:0];
    cond_nxt.deemphasis_listed = 1'b1;
    unique case (de_b)
      8'h01: cond_nxt.deemphasis_tenth_db = 8'h00;
      8'h38: cond_nxt.deemphasis_tenth_db = 8'h23;
      8'h88: cond_nxt.deemphasis_tenth_db = 8'h3C;
      8'h90: cond_nxt.deemphasis_tenth_db = 8'h5A;
      8'hA0: cond_nxt.deemphasis_tenth_db = 8'h78;
      default: cond_nxt.deemphasis_listed = 1'b0;
    endcase
    cond_nxt.idle_deassert_mv = thr_mv(th_b[THR_DEASSERT_LO+1:THR_DEASSERT_LO], 1'b1);
    cond_nxt.idle_assert_mv = thr_mv(th_b[1:0], 1'b0);
    cond_nxt.out_a_idle_auto = ir_b[IDLE_AUTO_BIT];
    cond_nxt.out_a_muted = ir_b[IDLE_AUTO_BIT] ? sy2_r[2] : ir_b[IDLE_SEL_BIT];
    cond_nxt.out_a_rate_auto = ir_b[RATE_AUTO_BIT];
    cond_nxt.out_a_rate_high = ir_b[RATE_AUTO_BIT] ? sy2_r[3] : ir_b[RATE_SEL_BIT];
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cond_r <= '0;
      sdata_r <= 1'b0;
    end else begin
      cond_r <= cond_nxt;
      sdata_r <= 1'b0;
    end
  end

  assign cond_out = cond_r;
  assign smb_data_out = sdata_r;
  assign smb_data_oe_n_out = oe_n_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  a_eq_field_split: assert property (##1 cond_r.gain_stage == $past(regs_w[IDX_EQ][4:3]))
    else $error("gain stage does not follow bits 4:3");
  a_eq_level_range: assert property (cond_r.eq_level_valid |-> cond_r.eq_level < 5'h18)
    else $error("equalizer level beyond 23");
  a_eq_reset_val: assert property ($past(rst_in) |-> regs_w[IDX_EQ] == 8'h20)
    else $error("equalizer byte not 0x20 after reset");
  a_eq_max_boost: assert property (regs_w[IDX_EQ] == 8'h3D |=> cond_r.eq_boost_tenth_db == 9'h11C)
    else $error("code 3D does not give 28.4 dB");
  a_swing_reserved: assert property (regs_w[IDX_SWING][6:0] == 7'h3F |=> !cond_r.output_swing_valid)
    else $error("reserved swing code marked valid");
  a_deemph_kind: assert property (##1 cond_r.deemphasis_kind == $past(regs_w[IDX_DEEMPH][7]))
    else $error("de-emphasis kind does not follow bit 7");
  a_deemph_12db: assert property (regs_w[IDX_DEEMPH] == 8'hA0 |=> cond_r.deemphasis_tenth_db == 8'h78)
    else $error("pattern A0 does not give -12 dB");
  a_idle_thr_pair: assert property (regs_w[IDX_IDLE_THR][3:0] == 4'hC |=>
    cond_r.idle_deassert_mv == 8'hBE && cond_r.idle_assert_mv == 8'h46)
    else $error("threshold pair wrong for code 1100");
  a_mute_manual: assert property (!regs_w[IDX_IDLE_RATE][5] |=>
    cond_r.out_a_muted == $past(regs_w[IDX_IDLE_RATE][4]))
    else $error("manual mute does not follow bit 4");
  a_rate_manual: assert property (!regs_w[IDX_IDLE_RATE][1] |=>
    cond_r.out_a_rate_high == $past(regs_w[IDX_IDLE_RATE][0]))
    else $error("manual rate does not follow bit 0");
  a_write_readback: assert property (wr_en_r |=> regs_w[$past(wr_idx_r)] == $past(wr_data_r))
    else $error("written byte not stored");

  c_write: cover property (wr_en_r);
  c_read_byte: cover property (state_r == ST_RDATA_ACK && mack_r == 1'b0);
  c_max_boost: cover property (cond_r.eq_boost_tenth_db == 9'h11C);

endmodule
`default_nettype wire

/* include/lccr_pkg.sv */
// Purpose: Shared constants, types and helpers for the lane conditioning configuration registers.
// Assumes: Registers are eight bits wide and are reached over the two-wire management bus.
// Notes: Offsets are the register pointer values that the host sends after the device address.
package lccr_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int NUM_REGS = 5;
  localparam logic [7:0] OFS_EQ = 8'h24;
  localparam logic [7:0] OFS_SWING = 8'h25;
  localparam logic [7:0] OFS_DEEMPH = 8'h26;
  localparam logic [7:0] OFS_IDLE_THR = 8'h27;
  localparam logic [7:0] OFS_IDLE_RATE = 8'h2B;

  localparam logic [2:0] IDX_EQ = 3'h0;
  localparam logic [2:0] IDX_SWING = 3'h1;
  localparam logic [2:0] IDX_DEEMPH = 3'h2;
  localparam logic [2:0] IDX_IDLE_THR = 3'h3;
  localparam logic [2:0] IDX_IDLE_RATE = 3'h4;

  localparam logic [7:0] RST_EQ = 8'h20;
  localparam logic [7:0] RST_SWING = 8'h03;
  localparam logic [7:0] RST_DEEMPH = 8'h03;
  localparam logic [7:0] RST_IDLE_THR = 8'h00;
  localparam logic [7:0] RST_IDLE_RATE = 8'h00;
  localparam logic [NUM_REGS-1:0][7:0] RST_ALL = {RST_IDLE_RATE, RST_IDLE_THR, RST_DEEMPH, RST_SWING, RST_EQ};

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int EQ_EN_BIT = 5;
  localparam int STAGE_HI = 4;
  localparam int STAGE_LO = 3;
  localparam int BOOST_HI = 2;
  localparam int SWING_HI = 6;
  localparam int DEEMPH_KIND_BIT = 7;
  localparam int DEEMPH_LVL_HI = 6;
  localparam int THR_DEASSERT_LO = 2;
  localparam int IDLE_AUTO_BIT = 5;
  localparam int IDLE_SEL_BIT = 4;
  localparam int RATE_AUTO_BIT = 1;
  localparam int RATE_SEL_BIT = 0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK, ST_SKIP
  } lccr_state_t;

  typedef struct packed {
    logic eq_enable;
    logic [1:0] gain_stage;
    logic [2:0] boost_level;
    logic [4:0] eq_level;
    logic eq_level_valid;
    logic [8:0] eq_boost_tenth_db;
    logic eq_code_listed;
    logic [10:0] output_swing_mv;
    logic output_swing_valid;
    logic deemphasis_kind;
    logic [6:0] deemphasis_level;
    logic [7:0] deemphasis_tenth_db;
    logic deemphasis_listed;
    logic [7:0] idle_deassert_mv;
    logic [7:0] idle_assert_mv;
    logic out_a_idle_auto;
    logic out_a_muted;
    logic out_a_rate_auto;
    logic out_a_rate_high;
  } lccr_cond_t;

  // Maps a register pointer to {hit, index}.
  function automatic logic [3:0] lccr_map(input logic [7:0] ptr);
    unique case (ptr)
      OFS_EQ: lccr_map = {1'b1, IDX_EQ};
      OFS_SWING: lccr_map = {1'b1, IDX_SWING};
      OFS_DEEMPH: lccr_map = {1'b1, IDX_DEEMPH};
      OFS_IDLE_THR: lccr_map = {1'b1, IDX_IDLE_THR};
      OFS_IDLE_RATE: lccr_map = {1'b1, IDX_IDLE_RATE};
      default: lccr_map = 4'h0;
    endcase
  endfunction

endpackage

/* verif/lane_conditioning_config_regs_bench.sv */
// Purpose: Self-checking bench for the lane conditioning configuration registers.
// Assumes: Device address 0x58; the pulled-up data line is resolved here.
// Notes: Detector inputs move 1 ns after a clock edge; bus timing comes from the host model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
  compares++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); \
  end \
end
module lane_conditioning_config_regs_bench
  import lccr_pkg::*;
;
  // *****************************
  // Harness
  // *****************************
  localparam logic [6:0] ADDR = 7'h58;
  logic sys_clk_in;
  logic rst_in = 1'b1;
  logic idle_det = 1'b0;
  logic rate_det = 1'b0;
  logic scl;
  logic host_low;
  logic sda;
  logic smb_data_out;
  logic smb_data_oe_n_out;
  lccr_cond_t cond;
  int n_errors = 0;
  int compares = 0;
  logic [7:0] d;
  logic [3:0] ir_got;
  logic [7:0] ofs [5] = '{OFS_EQ, OFS_SWING, OFS_DEEMPH, OFS_IDLE_THR, OFS_IDLE_RATE};
  logic [7:0] rsv [5] = '{8'h20, 8'h03, 8'h03, 8'h00, 8'h00};
  // Every written value keeps its reserved bits at zero.
  logic [7:0] eqc [8] = '{8'h2A, 8'h30, 8'h32, 8'h39, 8'h35, 8'h37, 8'h3B, 8'h3D};
  logic [8:0] eqd [8] = '{9'h032, 9'h05A, 9'h075, 9'h092, 9'h0B8, 9'h0C8, 9'h0D4, 9'h11C};
  logic [7:0] swc [5] = '{8'h03, 8'h07, 8'h0F, 8'h1F, 8'h3F};
  logic [11:0] swe [5] = '{12'hA58, 12'hB20, 12'hBE8, 12'hCB0, 12'h000};
  logic [7:0] dmc [5] = '{8'h01, 8'h38, 8'h88, 8'h90, 8'hA0};
  logic [7:0] dmd [5] = '{8'h00, 8'h23, 8'h3C, 8'h5A, 8'h78};
  logic [7:0] thd [4] = '{8'h6E, 8'h96, 8'hAA, 8'hBE};
  logic [7:0] tha [4] = '{8'h46, 8'h6E, 8'h82, 8'h96};
  logic [7:0] irc [4] = '{8'h11, 8'h00, 8'h32, 8'h23};
  logic [1:0] det [4] = '{2'h0, 2'h3, 2'h1, 2'h2};
  logic [3:0] ire [4] = '{4'h5, 4'h0, 4'hB, 4'hE};

  // The line is low when either party pulls it; otherwise the pull-up wins.
  assign sda = !(host_low || (!smb_data_oe_n_out && !smb_data_out));

  lccr_top #(.DEV_ADDR(ADDR)) lccr_top_i (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .smb_clk_in(scl),
    .smb_data_in(sda),
    .smb_data_out(smb_data_out),
    .smb_data_oe_n_out(smb_data_oe_n_out),
    .lane0_output_a_idle_detect_in(idle_det),
    .lane0_output_a_rate_detect_in(rate_det),
    .cond_out(cond)
  );

  lccr_host lccr_host_i (
    .sda_in(sda),
    .scl_out(scl),
    .sda_low_out(host_low)
  );

  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  initial begin
    repeat (100000) @(posedge sys_clk_in);
    n_errors++;
    $display("[ERR] %0t run did not finish", $time);
    tally_and_finish();
  end

  // *****************************
  // Access tasks
  // *****************************
  task automatic wr(input logic [7:0] ptr, input logic [7:0] v);
    logic [7:0] rx;
    logic a0;
    logic a1;
    logic a2;
    lccr_host_i.start();
    lccr_host_i.xfer({ADDR, 1'b0}, 1'b1, rx, a0);
    lccr_host_i.xfer(ptr, 1'b1, rx, a1);
    lccr_host_i.xfer(v, 1'b1, rx, a2);
    lccr_host_i.stop();
    `CHK({a0, a1, a2}, 3'h0)
    repeat (4) @(posedge sys_clk_in);
    #1;
  endtask

  task automatic rd(input logic [7:0] ptr, output logic [7:0] v);
    logic [7:0] rx;
    logic a0;
    logic a1;
    logic a2;
    logic a3;
    lccr_host_i.start();
    lccr_host_i.xfer({ADDR, 1'b0}, 1'b1, rx, a0);
    lccr_host_i.xfer(ptr, 1'b1, rx, a1);
    lccr_host_i.start();
    lccr_host_i.xfer({ADDR, 1'b1}, 1'b1, rx, a2);
    lccr_host_i.xfer(8'hFF, 1'b1, v, a3);
    lccr_host_i.stop();
    `CHK({a0, a1, a2}, 3'h0)
    repeat (4) @(posedge sys_clk_in);
    #1;
  endtask

  task automatic wrrd(input logic [7:0] ptr, input logic [7:0] v);
    logic [7:0] got;
    wr(ptr, v);
    rd(ptr, got);
    `CHK(got, v)
  endtask

  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // *****************************
  // Scenarios
  // *****************************
  initial begin
    repeat (20) @(posedge sys_clk_in);
    #1 rst_in = 1'b0;
    repeat (3) @(posedge sys_clk_in);
    #1;
    `CHK({cond.eq_enable, cond.gain_stage, cond.boost_level}, 6'h20)
    `CHK({cond.output_swing_valid, cond.output_swing_mv}, 12'hA58)
    `CHK({cond.idle_deassert_mv, cond.idle_assert_mv}, 16'h6E46)
    `CHK({cond.out_a_muted, cond.out_a_rate_high}, 2'h0)
    `CHK({cond.eq_code_listed, cond.eq_boost_tenth_db, cond.eq_level_valid, cond.eq_level}, 16'h8000)
    `CHK({cond.deemphasis_kind, cond.deemphasis_level, cond.deemphasis_listed}, 9'h006)
    `CHK({smb_data_out, smb_data_oe_n_out}, 2'h1)
    for (int i = 0; i < 5; i++) begin
      rd(ofs[i], d);
      `CHK(d, rsv[i])
    end
    for (int i = 0; i < 8; i++) begin
      wrrd(OFS_EQ, eqc[i]);
      `CHK({cond.eq_code_listed, cond.eq_boost_tenth_db}, {1'b1, eqd[i]})
      `CHK({cond.eq_enable, cond.gain_stage, cond.boost_level}, eqc[i][5:0])
      `CHK({cond.eq_level_valid, cond.eq_level}, {1'b1, 5'((eqc[i][4:3] - 1) * 8 + eqc[i][2:0])})
    end
    // An enabled equalizer with stage code zero and a nonzero boost is neither a level nor a listed code.
    wrrd(OFS_EQ, 8'h21);
    `CHK({cond.eq_code_listed, cond.eq_boost_tenth_db, cond.eq_level_valid, cond.eq_level}, 16'h0000)
    // The reserved swing code is stored but must not report a valid swing.
    for (int i = 0; i < 5; i++) begin
      wrrd(OFS_SWING, swc[i]);
      `CHK({cond.output_swing_valid, cond.output_swing_mv}, swe[i])
    end
    for (int i = 0; i < 5; i++) begin
      wrrd(OFS_DEEMPH, dmc[i]);
      `CHK({cond.deemphasis_kind, cond.deemphasis_level}, dmc[i])
      `CHK({cond.deemphasis_listed, cond.deemphasis_tenth_db}, {1'b1, dmd[i]})
    end
    for (int i = 0; i < 4; i++) begin
      wrrd(OFS_IDLE_THR, 8'(i * 4 + 3 - i));
      `CHK({cond.idle_deassert_mv, cond.idle_assert_mv}, {thd[i], tha[3 - i]})
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk_in);
      #1 {idle_det, rate_det} = det[i];
      wrrd(OFS_IDLE_RATE, irc[i]);
      ir_got = {cond.out_a_idle_auto, cond.out_a_muted, cond.out_a_rate_auto, cond.out_a_rate_high};
      `CHK(ir_got, ire[i])
    end
    // In automatic mode the outputs must track the detectors without a new write.
    @(posedge sys_clk_in);
    #1 {idle_det, rate_det} = 2'h1;
    repeat (4) @(posedge sys_clk_in);
    #1;
    `CHK({cond.out_a_muted, cond.out_a_rate_high}, 2'h1)
    #1 rst_in = 1'b1;
    repeat (2) @(posedge sys_clk_in);
    #1 rst_in = 1'b0;
    repeat (3) @(posedge sys_clk_in);
    #1;
    rd(OFS_EQ, d);
    `CHK(d, 8'h20)
    tally_and_finish();
  end
endmodule
`default_nettype wire

/* verif/lccr_host.sv */
// Purpose: Behavioural two-wire management host for the lane conditioning registers.
// Assumes: The data line has a pull-up; the bench resolves the wired level into sda_in.
// Notes: A quarter bit time of 31.25 ns gives the 125 ns bus clock, which stands high between frames.
`timescale 1ns/1ps
`default_nettype none
module lccr_host (
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  // *****************************
  // Bus primitives
  // *****************************
  localparam realtime Q = 31.25;

  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end

  // Start or repeated start; the clock is left low.
  task automatic start();
    sda_low_out = 1'b0;
    #Q scl_out = 1'b1;
    #Q sda_low_out = 1'b1;
    #Q scl_out = 1'b0;
    #Q;
  endtask

  task automatic stop();
    sda_low_out = 1'b1;
    #Q scl_out = 1'b1;
    #Q sda_low_out = 1'b0;
    #Q;
  endtask

  // Data moves a quarter period after the clock falls, so it never races a clock edge.
  task automatic put_bit(input logic b, output logic r);
    sda_low_out = !b;
    #Q scl_out = 1'b1;
    #Q r = sda_in;
    #Q scl_out = 1'b0;
    #Q;
  endtask

  // Eight bits MSB first, then the acknowledge slot; sending all ones releases the line for a read.
  task automatic xfer(input logic [7:0] tx, input logic ack_bit, output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put_bit(tx[i], r);
      rx[i] = r;
    end
    put_bit(ack_bit, ack);
  endtask
endmodule
`default_nettype wire
